// file: common/dac_cal_pkg.sv
// Constants shared by the converter calibration data path
package dac_cal_pkg;
  localparam int DATA_W = 14;
  localparam int CHANNELS = 32;
  localparam int ADDR_W = 5;
  localparam int SYNC_STAGES = 2;
  // Reset values
  localparam logic [13:0] GAIN_RESET = 14'h3ffe;
  localparam logic [13:0] OFFSET_RESET = 14'h2000;
  localparam logic [13:0] INPUT_RESET = 14'h0000;
  localparam logic [13:0] CODE_RESET = 14'h0000;
  localparam logic [13:0] CLEAR_CODE_RESET = 14'h0000;
  localparam logic [13:0] CTRL_RESET = 14'h2000;
  localparam logic [5:0] MON_CHAN_RESET = 6'h3f;
  // Correction arithmetic
  localparam logic [14:0] GAIN_BIAS = 15'h0002;
  localparam logic signed [17:0] OFFSET_MID = 18'sh02000;
  localparam logic signed [17:0] CODE_MAX = 18'sh03fff;
  localparam int GAIN_LSB = 0;
  // Control word bit positions
  localparam int CTRL_INT_REF_BIT = 10;
  localparam int CTRL_REF_MAG_BIT = 12;
  localparam int MON_CHAN_LSB = 8;
  // Register-select field values {high, low}
  localparam logic [1:0] SEL_INPUT = 2'h3;
  localparam logic [1:0] SEL_OFFSET = 2'h2;
  localparam logic [1:0] SEL_GAIN = 2'h1;
  localparam logic [1:0] SEL_SPECIAL = 2'h0;
  // Special function commands
  localparam logic [4:0] SFC_NOP = 5'h00;
  localparam logic [4:0] SFC_CLEAR_CODE = 5'h01;
  localparam logic [4:0] SFC_SOFT_CLEAR = 5'h02;
  localparam logic [4:0] SFC_POWER_DOWN = 5'h08;
  localparam logic [4:0] SFC_POWER_UP = 5'h09;
  localparam logic [4:0] SFC_MONITOR = 5'h0a;
  localparam logic [4:0] SFC_CTRL = 5'h0c;
  localparam logic [4:0] SFC_SOFT_RESET = 5'h0f;
endpackage

// file: common/cal_word_if.sv
// Carrier for one channel's coefficients and corrected code
`timescale 1ns/10ps
`default_nettype none
interface cal_word_if;
  logic [13:0] inWord;
  logic [13:0] gain;
  logic [13:0] offset;
  logic [13:0] code;
  modport corr (input inWord, input gain, input offset, output code);
  modport feed (output inWord, output gain, output offset, input code);
endinterface
`default_nettype wire

// file: logic/code_corrector.sv
// Gain and offset correction of one channel's input word
`timescale 1ns/10ps
`default_nettype none
module code_corrector
  import dac_cal_pkg::*;
(
  // Channel words
  cal_word_if.corr port
);
  logic [14:0] gainPlus2;
  logic [28:0] product;
  logic signed [17:0] scaled;
  logic signed [17:0] sum;
  logic tooLow;
  logic tooHigh;

  assign gainPlus2 = {1'b0, port.gain} + GAIN_BIAS;
  assign product = port.inWord * gainPlus2;
  assign scaled = $signed({3'h0, product[28:14]});
  // Offset binary: mid code is zero offset
  assign sum = scaled + $signed({4'h0, port.offset}) - OFFSET_MID;
  assign tooLow = sum < 18'sh00000;
  assign tooHigh = sum > CODE_MAX;
  assign port.code = tooLow ? 14'h0000 :
                     tooHigh ? 14'h3fff : sum[13:0];
endmodule
`default_nettype wire

// file: logic/dac_cal_datapath.sv
// Data path of the 32-channel calibrated converter
//
// What this block does
// - Register select routes 14-bit word: 11 input, 10 offset, 01 gain, 00 special.
// - Thirty-two channels, each with input, offset and gain registers.
// - Code equals input times (gain+2) over 2^14, plus offset minus 2^13.
// - Gain sits in bits 13..1; bit 0 is always zero.
// - Gain registers reset to 0x3FFE, unity gain.
// - Offset registers are 14 bits and reset to 0x2000, zero offset.
// - Offset is offset binary: 0x2000 zero, ones +8191, zeros -8192.
// - Gain all ones gives 1, 10 gives 0.75, 01 gives 0.5, zeros 2/16384.
// - Input word is straight binary; code scales output over 16384 steps.
// - Converter register code selects the resistor string tap per channel.
// - Channels are double-buffered; active-low load strobe updates all together.
// - Control bit picks internal reference; another picks 1.25 V or 2.5 V.
// - Select 00 decodes special command from address bits four to zero.
`timescale 1ns/10ps
`default_nettype none
module dac_cal_datapath
  import dac_cal_pkg::*;
#(
  parameter int NUM_CHANNELS = CHANNELS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Host write port, same clock domain
  input wire logic wrEn,
  input wire logic regSelectHigh,
  input wire logic regSelectLow,
  input wire logic [4:0] chanAddr,
  input wire logic [13:0] dataWordBits,
  // Load pin, asynchronous
  input wire logic loadUpdateStrobe_n,
  // Converter codes, channel 0 in the low bits
  output logic [NUM_CHANNELS*DATA_W-1:0] converterCodes,
  // Control state
  output logic [13:0] ctrlWord,
  output logic internalRefEnable,
  output logic refMagnitudeSelect,
  output logic powerDown,
  output logic [5:0] monitorChannel
);
  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  logic [13:0] inWord_q [NUM_CHANNELS];
  logic [13:0] gain_q [NUM_CHANNELS];
  logic [13:0] offset_q [NUM_CHANNELS];
  logic [13:0] code_q [NUM_CHANNELS];
  logic [13:0] corrected [NUM_CHANNELS];
  logic [13:0] clearCode_q;
  logic [13:0] ctrl_q;
  logic [5:0] monChan_q;
  logic powerDown_q;
  logic [SYNC_STAGES-1:0] loadSync_q;
  logic loadPrev_q;

  // ---------------------------------------------------------------
  // Write decode
  // ---------------------------------------------------------------
  logic [1:0] regSel;
  logic chanWrite;
  logic wrInput;
  logic wrOffset;
  logic wrGain;
  logic wrSpecial;
  logic [13:0] gainWord;
  logic cmdClearCode;
  logic cmdSoftClear;
  logic cmdPowerDown;
  logic cmdPowerUp;
  logic cmdMonitor;
  logic cmdCtrl;
  logic cmdSoftReset;
  logic loadLevel_n;
  logic loadFire;

  assign regSel = {regSelectHigh, regSelectLow};
  // Input, offset and gain writes are ignored while powered down
  assign chanWrite = wrEn && !powerDown_q;
  assign wrInput = chanWrite && (regSel == SEL_INPUT);
  assign wrOffset = chanWrite && (regSel == SEL_OFFSET);
  assign wrGain = chanWrite && (regSel == SEL_GAIN);
  assign wrSpecial = wrEn && (regSel == SEL_SPECIAL);
  assign gainWord = {dataWordBits[13:1], 1'b0};

  assign cmdClearCode = wrSpecial && !powerDown_q &&
                        (chanAddr == SFC_CLEAR_CODE);
  assign cmdSoftClear = wrSpecial && !powerDown_q &&
                        (chanAddr == SFC_SOFT_CLEAR);
  assign cmdPowerDown = wrSpecial && (chanAddr == SFC_POWER_DOWN);
  assign cmdPowerUp = wrSpecial && (chanAddr == SFC_POWER_UP);
  assign cmdMonitor = wrSpecial && !powerDown_q &&
                      (chanAddr == SFC_MONITOR);
  assign cmdCtrl = wrSpecial && !powerDown_q &&
                   (chanAddr == SFC_CTRL);
  assign cmdSoftReset = wrSpecial && (chanAddr == SFC_SOFT_RESET);

  // ---------------------------------------------------------------
  // Load strobe synchroniser and falling-edge detect
  // ---------------------------------------------------------------
  assign loadLevel_n = loadSync_q[SYNC_STAGES-1];
  // One update per assertion, however long the pin stays low
  assign loadFire = loadPrev_q && !loadLevel_n;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      loadSync_q <= '1;
      loadPrev_q <= 1'b1;
    end else begin
      loadSync_q <= {loadSync_q[SYNC_STAGES-2:0], loadUpdateStrobe_n};
      loadPrev_q <= loadLevel_n;
    end
  end

  // ---------------------------------------------------------------
  // Per-channel correction
  // ---------------------------------------------------------------
  for (genvar i = 0; i < NUM_CHANNELS; i++) begin : g_chan
    cal_word_if cw ();
    assign cw.inWord = inWord_q[i];
    assign cw.gain = gain_q[i];
    assign cw.offset = offset_q[i];
    assign corrected[i] = cw.code;
    code_corrector u_corr (
      .port (cw.corr)
    );
    assign converterCodes[i*DATA_W +: DATA_W] = code_q[i];
  end

  // ---------------------------------------------------------------
  // Channel input stage
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < NUM_CHANNELS; i++) begin
        inWord_q[i] <= INPUT_RESET;
        offset_q[i] <= OFFSET_RESET;
        gain_q[i] <= GAIN_RESET;
      end
    end else if (cmdSoftReset) begin
      for (int i = 0; i < NUM_CHANNELS; i++) begin
        inWord_q[i] <= INPUT_RESET;
        offset_q[i] <= OFFSET_RESET;
        gain_q[i] <= GAIN_RESET;
      end
    end else begin
      for (int i = 0; i < NUM_CHANNELS; i++) begin
        if (chanAddr == 5'(i)) begin
          if (wrInput) begin
            inWord_q[i] <= dataWordBits;
          end
          if (wrOffset) begin
            offset_q[i] <= dataWordBits;
          end
          if (wrGain) begin
            gain_q[i] <= gainWord;
          end
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Converter registers
  // ---------------------------------------------------------------
  // Soft reset beats soft clear, which beats a load in the same cycle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < NUM_CHANNELS; i++) begin
        code_q[i] <= CODE_RESET;
      end
    end else if (cmdSoftReset) begin
      for (int i = 0; i < NUM_CHANNELS; i++) begin
        code_q[i] <= CODE_RESET;
      end
    end else if (cmdSoftClear) begin
      for (int i = 0; i < NUM_CHANNELS; i++) begin
        code_q[i] <= clearCode_q;
      end
    end else if (loadFire) begin
      for (int i = 0; i < NUM_CHANNELS; i++) begin
        code_q[i] <= corrected[i];
      end
    end
  end

  // ---------------------------------------------------------------
  // Special function state
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      clearCode_q <= CLEAR_CODE_RESET;
      ctrl_q <= CTRL_RESET;
      monChan_q <= MON_CHAN_RESET;
      powerDown_q <= 1'b0;
    end else if (cmdSoftReset) begin
      clearCode_q <= CLEAR_CODE_RESET;
      ctrl_q <= CTRL_RESET;
      monChan_q <= MON_CHAN_RESET;
      powerDown_q <= 1'b0;
    end else begin
      if (cmdClearCode) begin
        clearCode_q <= dataWordBits;
      end
      if (cmdCtrl) begin
        ctrl_q <= dataWordBits;
      end
      if (cmdMonitor) begin
        monChan_q <= dataWordBits[13:MON_CHAN_LSB];
      end
      if (cmdPowerDown) begin
        powerDown_q <= 1'b1;
      end else if (cmdPowerUp) begin
        powerDown_q <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Control outputs
  // ---------------------------------------------------------------
  assign ctrlWord = ctrl_q;
  assign internalRefEnable = ctrl_q[CTRL_INT_REF_BIT];
  // Magnitude matters only while the internal reference is chosen
  assign refMagnitudeSelect = ctrl_q[CTRL_INT_REF_BIT] &&
                              ctrl_q[CTRL_REF_MAG_BIT];
  assign powerDown = powerDown_q;
  assign monitorChannel = monChan_q;
endmodule
`default_nettype wire

// file: testbench/dac_cal_datapath_chk.sv
// Port assertions for the calibration data path
`timescale 1ns/10ps
`default_nettype none
module dac_cal_datapath_chk
  import dac_cal_pkg::*;
#(parameter int NUM_CHANNELS = CHANNELS) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Host port
  input wire logic wrEn,
  input wire logic regSelectHigh,
  input wire logic regSelectLow,
  input wire logic [4:0] chanAddr,
  input wire logic [13:0] dataWordBits,
  input wire logic loadUpdateStrobe_n,
  // Outputs
  input wire logic [NUM_CHANNELS*DATA_W-1:0] converterCodes,
  input wire logic [13:0] ctrlWord,
  input wire logic internalRefEnable,
  input wire logic refMagnitudeSelect,
  input wire logic powerDown,
  input wire logic [5:0] monitorChannel
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  wire logic sfc = wrEn & !regSelectHigh & !regSelectLow;
  wire logic live = sfc & !powerDown;
  wire logic wipe = sfc & (chanAddr == SFC_SOFT_CLEAR
    || chanAddr == SFC_SOFT_RESET);
  property p_rst; $rose(arst_n) |-> ctrlWord == CTRL_RESET
    && monitorChannel == MON_CHAN_RESET && !powerDown; endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  property p_mag; refMagnitudeSelect == (ctrlWord[12] & ctrlWord[10]);
  endproperty
  a_mag: assert property (p_mag) else $error("magnitude wrong");
  property p_int; internalRefEnable == ctrlWord[10]; endproperty
  a_int: assert property (p_int) else $error("ref enable wrong");
  property p_ctl; live && chanAddr == SFC_CTRL |=>
    ctrlWord == $past(dataWordBits); endproperty
  a_ctl: assert property (p_ctl) else $error("control write lost");
  property p_mon; live && chanAddr == SFC_MONITOR |=>
    monitorChannel == $past(dataWordBits[13:8]); endproperty
  a_mon: assert property (p_mon) else $error("monitor write lost");
  property p_pd; sfc && chanAddr == SFC_POWER_DOWN |=> powerDown;
  endproperty
  a_pd: assert property (p_pd) else $error("no power down");
  property p_pu; sfc && chanAddr == SFC_POWER_UP |=> !powerDown;
  endproperty
  a_pu: assert property (p_pu) else $error("no power up");
  property p_ref; powerDown && live == 1'b0 && sfc
    && chanAddr == SFC_CTRL |=> $stable(ctrlWord); endproperty
  a_ref: assert property (p_ref) else $error("write in power down");
  property p_hold; !$stable(converterCodes) |-> !$past(loadUpdateStrobe_n, 2)
    || $past(wipe) || $past(wipe, 2); endproperty
  a_hold: assert property (p_hold) else $error("codes moved");
endmodule
`default_nettype wire

// file: testbench/host_writer.sv
// Host model driving words and the load pin
`timescale 1ns/10ps
`default_nettype none
module host_writer (
  // Clock
  input wire logic clk,
  // Write port and load pin
  output logic wrEn,
  output logic regSelectHigh,
  output logic regSelectLow,
  output logic [4:0] chanAddr,
  output logic [13:0] dataWordBits,
  output logic loadUpdateStrobe_n
);
  initial begin
    {wrEn, regSelectHigh, regSelectLow, chanAddr, dataWordBits} = '0;
    loadUpdateStrobe_n = 1'b1;
  end
  // Released address and data lines show the inverse, never the last word
  task automatic put(logic [1:0] sel, logic [4:0] a, logic [13:0] d);
    @(posedge clk);
    #1;
    {regSelectHigh, regSelectLow} = sel;
    chanAddr = a;
    dataWordBits = d;
    wrEn = 1'b1;
    @(posedge clk);
    #1;
    wrEn = 1'b0;
    chanAddr = ~a;
    dataWordBits = ~d;
  endtask
  task automatic load();
    @(posedge clk);
    #1;
    loadUpdateStrobe_n = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    loadUpdateStrobe_n = 1'b1;
    repeat (2) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// file: testbench/test_dac_cal_datapath.sv
// Self-checking bench for the calibration data path
`timescale 1ns/10ps
`default_nettype none
module test_dac_cal_datapath
  import dac_cal_pkg::*;
;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  wire logic wrEn, regSelectHigh, regSelectLow, loadUpdateStrobe_n;
  wire logic [4:0] chanAddr;
  wire logic [13:0] dataWordBits;
  logic [CHANNELS*DATA_W-1:0] converterCodes;
  logic [13:0] ctrlWord, ctrlE;
  logic internalRefEnable, refMagnitudeSelect, powerDown, pd;
  logic [5:0] monitorChannel, monE;
  logic [13:0] xs [CHANNELS], ms [CHANNELS], cs [CHANNELS], cd [CHANNELS];
  logic [13:0] clr;
  logic [19:0] q [$];
  logic [15:0] rnd = 16'd36334;
  int fails = 0, checksDone = 0;
  event note;
  always #5 clk = ~clk;
  host_writer i_host (.clk, .wrEn, .regSelectHigh, .regSelectLow,
    .chanAddr, .dataWordBits, .loadUpdateStrobe_n);
  dac_cal_datapath i_dut (.clk, .arst_n, .wrEn, .regSelectHigh,
    .regSelectLow, .chanAddr, .dataWordBits, .loadUpdateStrobe_n,
    .converterCodes, .ctrlWord, .internalRefEnable, .refMagnitudeSelect,
    .powerDown, .monitorChannel);
  // ----------------------------------------
  // Expected values and comparison
  // ----------------------------------------
  function automatic logic [13:0] rn();
    rnd = {rnd[14:0], rnd[15] ^ rnd[13] ^ rnd[12] ^ rnd[10]};
    return rnd[13:0];
  endfunction
  function automatic logic [13:0] corr(logic [13:0] x, m, c);
    longint v;
    v = ((x * (longint'(m) + 2)) >> 14) + c - 8192;
    if (v < 0) return 14'h0000;
    if (v > 16383) return 14'h3fff;
    return v[13:0];
  endfunction
  function automatic logic [13:0] seen(logic [5:0] i);
    if (i < 6'h20) return converterCodes[i*DATA_W+:DATA_W];
    if (i == 6'h20) return ctrlWord;
    if (i == 6'h21) return {12'h000, internalRefEnable, refMagnitudeSelect};
    if (i == 6'h22) return {13'h0000, powerDown};
    return {8'h00, monitorChannel};
  endfunction
  always @(note) begin
    logic [19:0] e;
    while (q.size() > 0) begin
      e = q.pop_front();
      checksDone++;
      if (seen(e[19:14]) !== e[13:0]) begin
        fails++;
        $display("Error %s %0d expected %h seen %h",
          e[19:14] < 6'h20 ? "converter code" : "control output",
          e[19:14], e[13:0], seen(e[19:14]));
      end
    end
  end
  task automatic check_all(string name);
    for (int i = 0; i < CHANNELS; i++) q.push_back({i[5:0], cd[i]});
    q.push_back({6'h20, ctrlE});
    q.push_back({6'h21, 12'h000, ctrlE[10], ctrlE[12] & ctrlE[10]});
    q.push_back({6'h22, 13'h0000, pd});
    q.push_back({6'h23, 8'h00, monE});
    ->note;
    #1;
    $display("test %s done", name);
  endtask
  task automatic rst_model();
    foreach (xs[i]) begin
      xs[i] = INPUT_RESET;
      ms[i] = GAIN_RESET;
      cs[i] = OFFSET_RESET;
      cd[i] = CODE_RESET;
    end
    {ctrlE, monE, pd} = {CTRL_RESET, MON_CHAN_RESET, 1'b0};
    clr = CLEAR_CODE_RESET;
  endtask
  task automatic wr(logic [1:0] sel, logic [4:0] a, logic [13:0] d);
    i_host.put(sel, a, d);
    if (sel == SEL_SPECIAL && a == SFC_POWER_DOWN) pd = 1'b1;
    if (sel == SEL_SPECIAL && a == SFC_POWER_UP) pd = 1'b0;
    if (pd) return;
    if (sel == SEL_INPUT) xs[a] = d;
    if (sel == SEL_OFFSET) cs[a] = d;
    if (sel == SEL_GAIN) ms[a] = d & 14'h3ffe;
    if (sel == SEL_SPECIAL && a == SFC_CTRL) ctrlE = d;
    if (sel == SEL_SPECIAL && a == SFC_MONITOR) monE = d[13:8];
    if (sel == SEL_SPECIAL && a == SFC_CLEAR_CODE) clr = d;
    // Soft clear lands on the same edge that takes the command
    if (sel == SEL_SPECIAL && a == SFC_SOFT_CLEAR) begin
      foreach (cd[i]) cd[i] = clr;
    end
  endtask
  task automatic ld(string name);
    i_host.load();
    foreach (cd[i]) cd[i] = corr(xs[i], ms[i], cs[i]);
    check_all(name);
  endtask
  task automatic stop_test();
    $display("checks %0d fails %0d", checksDone, fails);
    if (fails == 0 && checksDone > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #500000;
    fails++;
    stop_test();
  end
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    logic [13:0] ctl [4] = '{14'h2000, 14'h0400, 14'h1400, 14'h1000};
    logic [13:0] gn [6] = '{GAIN_RESET, 14'h2ffe, 14'h1ffe, 14'h0000,
      14'h3fff, 14'h3ffe};
    rst_model();
    repeat (4) @(posedge clk);
    #1 arst_n = 1'b1;
    repeat (2) @(posedge clk);
    check_all("reset");
    for (int i = 0; i < CHANNELS; i++) wr(SEL_INPUT, i[4:0], rn());
    check_all("buffered");
    ld("unity");
    for (int i = 0; i < CHANNELS; i++) begin
      wr(SEL_GAIN, i[4:0], rn());
      wr(SEL_OFFSET, i[4:0], rn());
    end
    ld("random coeffs");
    for (int i = 0; i < 6; i++) begin
      wr(SEL_GAIN, i[4:0], gn[i]);
      wr(SEL_OFFSET, i[4:0], i[0] ? 14'h3fff : 14'h0000);
      wr(SEL_INPUT, i[4:0], i > 3 ? 14'h3fff : 14'h0010);
    end
    ld("gain table");
    foreach (ctl[i]) begin
      wr(SEL_SPECIAL, SFC_CTRL, ctl[i]);
      check_all("control");
    end
    wr(SEL_SPECIAL, SFC_MONITOR, 14'h1500);
    wr(SEL_SPECIAL, SFC_NOP, 14'h2aaa);
    wr(SEL_SPECIAL, SFC_POWER_DOWN, rn());
    wr(SEL_INPUT, 5'h07, rn());
    wr(SEL_SPECIAL, SFC_CTRL, 14'h0400);
    check_all("power down");
    wr(SEL_SPECIAL, SFC_POWER_UP, rn());
    ld("power up");
    wr(SEL_SPECIAL, SFC_CLEAR_CODE, rn());
    wr(SEL_SPECIAL, SFC_SOFT_CLEAR, rn());
    check_all("soft clear");
    wr(SEL_SPECIAL, SFC_SOFT_RESET, rn());
    rst_model();
    check_all("soft reset");
    wr(SEL_INPUT, 5'h03, rn());
    ld("soft reset load");
    stop_test();
  end
endmodule
bind dac_cal_datapath dac_cal_datapath_chk #(.NUM_CHANNELS(NUM_CHANNELS))
  i_chk (.clk, .arst_n, .wrEn, .regSelectHigh, .regSelectLow, .chanAddr,
  .dataWordBits, .loadUpdateStrobe_n, .converterCodes, .ctrlWord,
  .internalRefEnable, .refMagnitudeSelect, .powerDown, .monitorChannel);
`default_nettype wire
